// File: mbag_pkg.sv
// Purpose: Shared types and constants of the X data address generator
// Assumes: 16-bit data addresses, 32-bit AXI4-Lite register bus
// Notes:   Offsets, field positions and reset values live only here

`default_nettype none

package mbag_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_BREV  = 8'h00;
	localparam logic [7:0]  ADDR_CIRC  = 8'h04;
	localparam logic [7:0]  ADDR_START = 8'h08;
	localparam logic [7:0]  ADDR_END   = 8'h0c;
	localparam logic [7:0]  ADDR_STAT  = 8'h10;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int          REV_EN_BIT    = 15;
	localparam int          CIRC_EN_BIT   = 15;
	localparam int          CIRC_SEL_LSB  = 4;
	localparam int          BREV_SEL_LSB  = 0;
	localparam logic [3:0]  STACK_REG     = 4'hf;
	localparam logic [15:0] RST_BREV      = 16'h0000;
	localparam logic [15:0] RST_CIRC      = 16'h000f;
	localparam logic [15:0] RST_START     = 16'h0000;
	localparam logic [15:0] RST_END       = 16'hffff;
	localparam logic [15:0] WORD_STEP     = 16'h0002;
	localparam logic [15:0] BYTE_STEP     = 16'h0001;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// Addressing modes of one data access
	typedef enum logic [2:0] {
		MODE_INDIRECT = 3'b000,
		MODE_POST_INC = 3'b001,
		MODE_POST_DEC = 3'b010,
		MODE_PRE_INC  = 3'b011,
		MODE_PRE_DEC  = 3'b100,
		MODE_OFFSET   = 3'b101
	} mbag_mode_e;

	// Access request from instruction decode
	typedef struct packed {
		logic        valid;
		logic        is_write;
		logic        is_byte;
		mbag_mode_e  mode;
		logic [3:0]  reg_sel;
		logic [15:0] ptr;
		logic [15:0] offset;
	} mbag_req_s;

	// Generated address and pointer write-back
	typedef struct packed {
		logic        addr_valid;
		logic [15:0] effective_addr;
		logic        wb_valid;
		logic [3:0]  wb_reg;
		logic [15:0] wb_data;
		logic        rev_used;
		logic        circ_used;
	} mbag_res_s;

	// Wrap an address back into the circular window
	function automatic logic [15:0] mbag_modulo_fix(
		input logic [15:0] value,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		logic [15:0] span;
		span = 16'(hi - lo + 16'h0001);
		if (value > hi)
			return 16'(value - span);
		else if (value < lo)
			return 16'(value + span);
		return value;
	endfunction : mbag_modulo_fix

endpackage : mbag_pkg

`default_nettype wire

// File: mbag_rev_add.sv
// Purpose: Reverse-carry adder for bit-reversed pointer stepping
// Assumes: Word data, bit 0 of the result is always clear
// Notes:   Carries run from high bits toward bit 1

`timescale 1ns/1ps
`default_nettype none

module mbag_rev_add
	import mbag_pkg::*;
(
	input  wire logic [15:0] ptr_i,
	input  wire logic [14:0] pivot_i,
	output logic      [15:0] sum_o
);

	logic [15:0] mod_w;
	logic [14:0] ra;
	logic [14:0] rb;
	logic [14:0] rs;

	// Scale pivot to bytes, then add with mirrored bit order
	always_comb
	begin
		mod_w = {pivot_i, 1'b0};
		for (int i = 0; i < 15; i++)
		begin
			ra[i] = ptr_i[15 - i];
			rb[i] = mod_w[15 - i];
		end
		rs = 15'(ra + rb);
		sum_o = 16'h0000;
		for (int i = 0; i < 15; i++)
			sum_o[15 - i] = rs[i];
	end

endmodule : mbag_rev_add

`default_nettype wire

// File: mbag_top.sv
// Purpose: X data address generator, circular and bit-reversed modes
// Assumes: Request from same-clock decode, answer one cycle later
// Notes:   Registers on AXI4-Lite, 32-bit words, 16 low bits used
//
// Behaviour
// - Circular correction may use any working register as pointer.
// - Bounds are crossed by compare beyond end or below start.
// - Corrected value is written back only for pre or post modify.
// - Bit reversal applies to X writes only, never to reads.
// - Only the modifier is bit-reversed, addresses stay in order.
// - Reversal needs pointer select not 15, enable set, pre/post inc.
// - A 15-bit pivot sits in bits 14:0 of the reversal control.
// - Reversed addresses are word addresses, pivot scaled, bit 0 clear.
// - Byte writes or other modes fall back to normal addressing.
// - Active reversal adds the pivot and ignores the mode increment.
// - With both on, reversal wins on writes, reads keep circular.

`timescale 1ns/1ps
`default_nettype none

module mbag_top
	import mbag_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire mbag_req_s   req_i,
	output var  mbag_res_s   res_o,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [15:0] bit_reverse_control;
	logic [15:0] circular_buffer_control;
	logic [15:0] mod_start;
	logic [15:0] mod_end;
	logic [7:0]  aw_addr;
	logic        aw_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_held;

	logic        reversal_enable;
	logic [14:0] reversal_pivot;
	logic [3:0]  reversal_pointer_select;
	logic        circ_en;
	logic [3:0]  circ_sel;

	assign reversal_enable         = bit_reverse_control[REV_EN_BIT];
	assign reversal_pivot          = bit_reverse_control[14:0];
	assign reversal_pointer_select = circular_buffer_control[BREV_SEL_LSB+:4];
	assign circ_sel                = circular_buffer_control[CIRC_SEL_LSB+:4];
	assign circ_en                 = circular_buffer_control[CIRC_EN_BIT];

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	logic        wr_go;
	logic        wr_hit;
	logic [15:0] wr_lane;

	assign wr_go  = aw_held && w_held && !s_axi_bvalid_o;
	assign wr_hit = (aw_addr == ADDR_BREV) || (aw_addr == ADDR_CIRC) ||
		(aw_addr == ADDR_START) || (aw_addr == ADDR_END) ||
		(aw_addr == ADDR_STAT);

	// Merge byte lanes of the low half into the old value
	function automatic logic [15:0] merge_lanes(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [1:0]  strb
	);
		return {strb[1] ? new_v[15:8] : old_v[15:8],
			strb[0] ? new_v[7:0] : old_v[7:0]};
	endfunction : merge_lanes

	assign wr_lane = w_data[15:0];

	// Address and data taken in either order, held until the write
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			else if (wr_go)
				aw_held <= 1'b0;
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			else if (wr_go)
				w_held <= 1'b0;
		end
	end

	// Ready only while the slot is empty
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
		end
		else
		begin
			s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o);
			s_axi_wready_o  <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o);
		end
	end

	// Response; status word is read-only, so a write there errors
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= (wr_hit && aw_addr != ADDR_STAT) ?
				RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready_i)
			s_axi_bvalid_o <= 1'b0;
	end

	// Configuration storage; a new value steers the next request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bit_reverse_control     <= RST_BREV;
			circular_buffer_control <= RST_CIRC;
			mod_start               <= RST_START;
			mod_end                 <= RST_END;
		end
		else if (wr_go)
		begin
			case (aw_addr)
				ADDR_BREV:
					bit_reverse_control <= merge_lanes(bit_reverse_control,
						wr_lane, w_strb[1:0]);
				ADDR_CIRC:
					circular_buffer_control <= merge_lanes(
						circular_buffer_control, wr_lane, w_strb[1:0]);
				ADDR_START:
					mod_start <= merge_lanes(mod_start, wr_lane, w_strb[1:0]);
				ADDR_END:
					mod_end <= merge_lanes(mod_end, wr_lane, w_strb[1:0]);
				default:
					;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	logic [15:0] rd_val;
	logic        rd_hit;

	always_comb
	begin
		rd_hit = 1'b1;
		case (s_axi_araddr_i)
			ADDR_BREV:  rd_val = bit_reverse_control;
			ADDR_CIRC:  rd_val = circular_buffer_control;
			ADDR_START: rd_val = mod_start;
			ADDR_END:   rd_val = mod_end;
			ADDR_STAT:  rd_val = res_o.effective_addr;
			default:
			begin
				rd_val = 16'h0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// One read at a time, data one cycle after the address
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= {16'h0000, rd_val};
			s_axi_rresp_o   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid_o)
		begin
			if (s_axi_rready_i)
			begin
				s_axi_rvalid_o  <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
		else
			s_axi_arready_o <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Address generation
	// ----------------------------------------------------------------
	logic [15:0] rev_sum;
	logic        rev_cfg;
	logic        rev_act;
	logic        circ_act;
	logic        is_pre;
	logic        is_post;
	logic [15:0] step;
	logic [15:0] upd;
	logic [15:0] fixed;
	mbag_res_s   next_res;

	mbag_rev_add u_rev_add (
		.ptr_i   (req_i.ptr),
		.pivot_i (reversal_pivot),
		.sum_o   (rev_sum)
	);

	always_comb
	begin
		is_pre  = (req_i.mode == MODE_PRE_INC) || (req_i.mode == MODE_PRE_DEC);
		is_post = (req_i.mode == MODE_POST_INC) ||
			(req_i.mode == MODE_POST_DEC);
		rev_cfg = reversal_enable &&
			(reversal_pointer_select != STACK_REG);
		// Only word writes through the chosen pointer reverse
		rev_act = rev_cfg && req_i.is_write && !req_i.is_byte &&
			(req_i.reg_sel == reversal_pointer_select) &&
			(req_i.mode == MODE_PRE_INC ||
			req_i.mode == MODE_POST_INC);
		// Reversal silences circular mode on writes only
		circ_act = circ_en && (req_i.reg_sel == circ_sel) &&
			!(req_i.is_write && rev_cfg);
		step = req_i.is_byte ? BYTE_STEP : WORD_STEP;
		case (req_i.mode)
			MODE_POST_INC, MODE_PRE_INC: upd = 16'(req_i.ptr + step);
			MODE_POST_DEC, MODE_PRE_DEC: upd = 16'(req_i.ptr - step);
			MODE_OFFSET:                 upd = 16'(req_i.ptr + req_i.offset);
			default:                     upd = req_i.ptr;
		endcase
		fixed = circ_act ? mbag_modulo_fix(upd, mod_start, mod_end) :
			upd;
		next_res = '0;
		next_res.addr_valid = req_i.valid;
		next_res.wb_reg     = req_i.reg_sel;
		next_res.rev_used   = req_i.valid && rev_act;
		next_res.circ_used  = req_i.valid && circ_act && !rev_act;
		next_res.wb_valid   = req_i.valid && (is_pre || is_post);
		// Pivot replaces the mode step, pointer kept in plain order
		next_res.wb_data    = rev_act ? rev_sum : fixed;
		if (rev_act)
			next_res.effective_addr = is_pre ? rev_sum :
				{req_i.ptr[15:1], 1'b0};
		else if (is_pre || req_i.mode == MODE_OFFSET)
			next_res.effective_addr = fixed;
		else
			next_res.effective_addr = req_i.ptr;
	end

	// Result register; control written the cycle before applies here
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			res_o <= '0;
		else
			res_o <= next_res;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	rev_lsb_clear_a: assert property (res_o.rev_used |->
		res_o.effective_addr[0] == 1'b0 && res_o.wb_data[0] == 1'b0)
		else $error("reversed address has bit 0 set");
	offset_no_wb_a: assert property (req_i.valid &&
		req_i.mode == MODE_OFFSET |=> !res_o.wb_valid)
		else $error("offset mode wrote back the pointer");
	read_no_rev_a: assert property (req_i.valid &&
		!req_i.is_write |=> !res_o.rev_used)
		else $error("bit reversal on a read");
	stack_no_rev_a: assert property (
		reversal_pointer_select == STACK_REG |=> !res_o.rev_used)
		else $error("bit reversal through register 15");
	byte_no_rev_a: assert property (req_i.valid &&
		(req_i.is_byte || req_i.mode == MODE_OFFSET) |=> !res_o.rev_used)
		else $error("bit reversal on byte or wrong mode");
	rev_post_addr_a: assert property (req_i.valid &&
		req_i.mode == MODE_POST_INC ##1 res_o.rev_used |->
		res_o.effective_addr == {$past(req_i.ptr[15:1]), 1'b0})
		else $error("post increment address not the pointer");
	write_prio_a: assert property (req_i.valid &&
		req_i.is_write && rev_cfg |=> !res_o.circ_used)
		else $error("circular correction on reversed write path");
	circ_range_a: assert property (req_i.valid && circ_act &&
		(is_pre || is_post) && req_i.ptr >= mod_start &&
		req_i.ptr <= mod_end && mod_end > mod_start |=>
		res_o.wb_data >= $past(mod_start) &&
		res_o.wb_data <= $past(mod_end))
		else $error("circular pointer left the window");
	rev_step_a: assert property (req_i.valid && rev_act |=>
		res_o.wb_valid && res_o.wb_data == $past(rev_sum))
		else $error("reversed pointer not stepped by pivot");

	rev_write_c: cover property (res_o.rev_used && res_o.wb_valid);
	circ_wrap_c: cover property (res_o.circ_used &&
		res_o.wb_data != res_o.effective_addr);
	reg_write_c: cover property (s_axi_bvalid_o && s_axi_bready_i);
	both_on_c: cover property (circ_en && rev_cfg && res_o.circ_used);

endmodule : mbag_top

`default_nettype wire

// File: mbag_core_model.sv
// Purpose: Core decode model that issues X data address requests
// Assumes: One request per call, held valid for exactly one cycle
// Notes:   Answers are sampled by the caller one cycle later

`timescale 1ns/1ps
`default_nettype none

module mbag_core_model
	import mbag_pkg::*;
(
	input  wire logic clk_i,
	output var  mbag_req_s req_o
);
	// ------------------------------------------------------------
	// Request issue
	// ------------------------------------------------------------
	initial req_o = '0;

	// Pointers come from the caller as given, odd values included
	// Each issue waits an edge, so a control write is never
	// followed directly by a pointer access
	task automatic issue(input mbag_req_s r);
		@(posedge clk_i);
		req_o <= r;
		@(posedge clk_i);
		req_o <= '0;
	endtask : issue
endmodule : mbag_core_model

`default_nettype wire

// File: tb_modulo_bitrev_address_gen.sv
// Purpose: Self-checking bench for the X data address generator
// Assumes: Registers over AXI4-Lite, answers one cycle after request
// Notes:   Expected addresses are worked out by hand below

`timescale 1ns/1ps
`default_nettype none

module tb_modulo_bitrev_address_gen
	import mbag_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clk_i   = 1'b0;
	logic        rst_i   = 1'b1;
	mbag_req_s   req;
	mbag_res_s   res;
	logic [7:0]  awaddr  = '0;
	logic [7:0]  araddr  = '0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic [31:0] wdata   = '0;
	logic [3:0]  wstrb   = '0;
	logic [31:0] rdata;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	int          fails   = 0;
	int          samples_checked = 0;

	// 20 MHz clock
	always #25 clk_i = ~clk_i;

	mbag_core_model core_u (.clk_i(clk_i), .req_o(req));

	mbag_top dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .res_o(res),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready)
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic test_done();
		if (fails == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [1:0] er, input logic [3:0] s = 4'h3);
		int n = 0;
		@(posedge clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {16'h0000, d};
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			n++;
		end
		while (bvalid !== 1'b1 && n < 40);
		bready <= 1'b0;
		check(32'(bvalid), 32'h1);
		check(32'(bresp), 32'(er));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n = 0;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (arready)
				arvalid <= 1'b0;
			n++;
		end
		while (rvalid !== 1'b1 && n < 40);
		rready <= 1'b0;
		check(rdata, ed);
		check(32'(rresp), 32'(er));
	endtask : rd

	// One access; rv is 2 for circular use, 1 for reversal use
	task automatic acc(input int w, b, input mbag_mode_e m,
		input int r, p, o, xa, wv, wb, rv);
		mbag_req_s q;
		q = '{1'b1, 1'(w), 1'(b), m, 4'(r), 16'(p), 16'(o)};
		core_u.issue(q);
		#1;
		check(32'({res.addr_valid, res.wb_valid, res.circ_used, res.rev_used,
			res.effective_addr}), 32'({1'b1, 1'(wv), 2'(rv), 16'(xa)}));
		if (wv != 0)
			check(32'({res.wb_reg, res.wb_data}), 32'({4'(r), 16'(wb)}));
	endtask : acc

	// ------------------------------------------------------------
	// Watchdog at 5000 cycles, far above the some 120 cycles the tests need
	// ------------------------------------------------------------
	initial
	begin
		#(50 * 5000);
		fails++;
		test_done();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(ADDR_BREV, 32'(RST_BREV), RESP_OKAY);
		rd(ADDR_CIRC, 32'(RST_CIRC), RESP_OKAY);
		rd(ADDR_START, 32'(RST_START), RESP_OKAY);
		rd(ADDR_END, 32'(RST_END), RESP_OKAY);
		rd(8'h14, 32'h0, RESP_SLVERR);
		wr(8'h10, 16'h1234, RESP_SLVERR);
		wr(ADDR_BREV, 16'hffff, RESP_OKAY);
		rd(ADDR_BREV, 32'h0000ffff, RESP_OKAY);
		wr(ADDR_BREV, 16'h0000, RESP_OKAY);
		// Plain modes, nothing enabled
		acc(0,0,MODE_POST_INC,1,'h0100,0,'h0100,1,'h0102,0);
		acc(0,1,MODE_PRE_DEC,1,'h0100,0,'h00ff,1,'h00ff,0);
		acc(0,0,MODE_OFFSET,1,'h0100,'h0010,'h0110,0,0,0);
		acc(0,0,MODE_INDIRECT,1,'h0100,0,'h0100,0,0,0);
		// Circular window 1000..100f on pointer 2
		wr(ADDR_START, 16'h1000, RESP_OKAY);
		wr(ADDR_END, 16'h100f, RESP_OKAY);
		wr(ADDR_CIRC, 16'h802f, RESP_OKAY);
		acc(0,0,MODE_POST_INC,2,'h100e,0,'h100e,1,'h1000,2);
		acc(1,0,MODE_PRE_DEC,2,'h1000,0,'h100e,1,'h100e,2);
		acc(0,0,MODE_OFFSET,2,'h1008,'h000a,'h1002,0,0,2);
		acc(0,0,MODE_POST_INC,3,'h100e,0,'h100e,1,'h1010,0);
		acc(1,0,MODE_POST_INC,2,'h100e,0,'h100e,1,'h1000,2);
		// Reversal on pointer 2, pivot 8, circular also on
		wr(ADDR_BREV, 16'h8008, RESP_OKAY);
		wr(ADDR_CIRC, 16'h8022, RESP_OKAY);
		acc(1,0,MODE_POST_INC,2,'h1000,0,'h1000,1,'h1010,1);
		acc(1,0,MODE_POST_INC,2,'h1010,0,'h1010,1,'h1008,1);
		acc(1,0,MODE_PRE_INC,2,'h1009,0,'h1018,1,'h1018,1);
		acc(1,1,MODE_POST_INC,2,'h1000,0,'h1000,1,'h1001,0);
		acc(1,0,MODE_POST_DEC,2,'h1004,0,'h1004,1,'h1002,0);
		acc(0,0,MODE_POST_INC,2,'h100e,0,'h100e,1,'h1000,2);
		acc(1,0,MODE_POST_INC,3,'h1000,0,'h1000,1,'h1002,0);
		acc(1,0,MODE_POST_INC,2,'h0ffe,0,'h0ffe,1,'h0fe0,1);
		// Stack pointer select, then enable bit clear
		wr(ADDR_CIRC, 16'h000f, RESP_OKAY);
		acc(1,0,MODE_POST_INC,15,'h0200,0,'h0200,1,'h0202,0);
		wr(ADDR_BREV, 16'h0008, RESP_OKAY);
		wr(ADDR_CIRC, 16'h0002, RESP_OKAY);
		acc(1,0,MODE_POST_INC,2,'h1000,0,'h1000,1,'h1002,0);
		acc(1,0,MODE_PRE_INC,2,'h2000,0,'h2002,1,'h2002,0);
		// Low byte lane only, high byte of the end bound kept
		wr(ADDR_END, 16'h0000, RESP_OKAY, 4'h1);
		rd(ADDR_END, 32'h0000_1000, RESP_OKAY);
		test_done();
	end
endmodule : tb_modulo_bitrev_address_gen

`default_nettype wire
